// ==== design/annp_regs.sv ====
`timescale 1ns/1ps
module annp_regs #(
   parameter logic [4:0]  TECH_ABILITY = 5'h1f,
   parameter logic [4:0]  SELECTOR     = 5'h01,
   parameter logic        AN_ABLE      = 1'b1,
   parameter logic        NP_ABLE      = 1'b1,
   parameter logic [10:0] CODE_MAX     = 11'h00f
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic [4:0]  MGMT_ADDR,
   input  wire logic [15:0] MGMT_WDATA,
   input  wire logic        MGMT_WE,
   input  wire logic        MGMT_RE,
   output logic      [15:0] MGMT_RDATA,
   input  wire logic        RX_PAGE_VALID,
   input  wire logic        RX_IS_BASE,
   input  wire logic [15:0] RX_PAGE,
   input  wire logic        LP_AN_ABLE,
   input  wire logic        PD_FAULT,
   input  wire logic        BASE_DONE,
   input  wire logic        AN_INITIATED,
   input  wire logic        AN_COMPLETE,
   input  wire logic        TX_NP_TAKEN,
   output logic             AN_ENABLE,
   output logic             AN_RESTART,
   output logic             FORCE_SPEED,
   output logic             FORCE_DUPLEX,
   output logic      [15:0] TX_BASE_PAGE,
   output logic      [15:0] TX_NEXT_PAGE,
   output logic             TX_NP_READY,
   output logic             NP_EXCHANGE,
   output logic             NP_DONE
);
   logic [15:0] ctrl_reg;
   logic        restart_reg;
   logic [15:0] adv_reg, adv_next;
   logic [15:0] lp_reg;
   logic [15:0] np_tx_reg;
   logic        rf_status_reg;
   logic        page_rcvd_reg;
   logic        pd_fault_reg;
   logic        lp_np_able_reg;
   logic        lp_an_able_reg;
   logic [7:0]  tech_mask;
   logic [15:0] adv_reset;
   logic        wr_ctrl, wr_adv, wr_np;
   logic        rd_status, rd_exp;
   logic        rx_base, rx_next, rx_rfault;
   logic        an_cmpl;
   logic [15:0] status_word, ctrl_word, exp_word;
   logic [15:0] rd_mux;
   logic        seq_restart;

   // ==========================================
   // decode
   assign wr_ctrl   = MGMT_WE && (MGMT_ADDR == annp_pkg::ADDR_CTRL);
   assign wr_adv    = MGMT_WE && (MGMT_ADDR == annp_pkg::ADDR_ADV);
   assign wr_np     = MGMT_WE && (MGMT_ADDR == annp_pkg::ADDR_NP_TX) && NP_ABLE;
   assign rd_status = MGMT_RE && (MGMT_ADDR == annp_pkg::ADDR_STATUS);
   assign rd_exp    = MGMT_RE && (MGMT_ADDR == annp_pkg::ADDR_EXP);
   assign rx_base   = RX_PAGE_VALID && RX_IS_BASE;
   assign rx_next   = RX_PAGE_VALID && !RX_IS_BASE && NP_EXCHANGE;
   assign rx_rfault = rx_base && RX_PAGE[annp_pkg::PG_RFAULT];
   assign tech_mask = {3'b000, TECH_ABILITY};
   // technology field mirrors status ability bits, ack forced low
   assign adv_reset = {NP_ABLE, 1'b0, 1'b0, tech_mask, SELECTOR};
   assign seq_restart = wr_ctrl && MGMT_WDATA[annp_pkg::CTRL_RESTART] && AN_ABLE;

   // ==========================================
   // read side
   assign an_cmpl     = AN_COMPLETE && ctrl_reg[annp_pkg::CTRL_AN_EN] && AN_ABLE;
   assign status_word = {TECH_ABILITY, 5'h00, an_cmpl, rf_status_reg, AN_ABLE,
                         3'b000};
   assign ctrl_word   = {2'b00, ctrl_reg[annp_pkg::CTRL_SPEED],
                         ctrl_reg[annp_pkg::CTRL_AN_EN], 2'b00, restart_reg,
                         ctrl_reg[annp_pkg::CTRL_DUPLEX], 8'h00};
   assign exp_word    = {11'h000, pd_fault_reg, lp_np_able_reg, NP_ABLE,
                         page_rcvd_reg, lp_an_able_reg};
   // unmapped addresses read zero; register 7 only exists with next page support
   assign rd_mux = (MGMT_ADDR == annp_pkg::ADDR_CTRL)   ? ctrl_word :
                   (MGMT_ADDR == annp_pkg::ADDR_STATUS) ? status_word :
                   (MGMT_ADDR == annp_pkg::ADDR_ADV)    ? adv_reg :
                   (MGMT_ADDR == annp_pkg::ADDR_LP)     ? lp_reg :
                   (MGMT_ADDR == annp_pkg::ADDR_EXP)    ? exp_word :
                   (MGMT_ADDR == annp_pkg::ADDR_NP_TX && NP_ABLE) ?
                   (np_tx_reg & annp_pkg::NP_TX_WR_MASK) : 16'h0000;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         MGMT_RDATA <= 16'h0000;
      end else if (MGMT_RE) begin
         MGMT_RDATA <= rd_mux;
      end
   end

   // ==========================================
   // control register
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_reg <= annp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= MGMT_WDATA & 16'h3100;
      end
   end

   // not yet initiated after reset, so the bit reads one until then
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         restart_reg <= 1'b1;
         AN_RESTART  <= 1'b0;
      end else begin
         AN_RESTART <= seq_restart;
         if (seq_restart) begin
            restart_reg <= 1'b1;
         end else if (AN_INITIATED) begin
            restart_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         AN_ENABLE    <= 1'b0;
         FORCE_SPEED  <= 1'b0;
         FORCE_DUPLEX <= 1'b0;
      end else begin
         AN_ENABLE    <= ctrl_reg[annp_pkg::CTRL_AN_EN] && AN_ABLE;
         FORCE_SPEED  <= !ctrl_reg[annp_pkg::CTRL_AN_EN] &&
                         ctrl_reg[annp_pkg::CTRL_SPEED];
         FORCE_DUPLEX <= !ctrl_reg[annp_pkg::CTRL_AN_EN] &&
                         ctrl_reg[annp_pkg::CTRL_DUPLEX];
      end
   end

   // ==========================================
   // advertisement register
   // the ack position is read-only zero; remote fault drops once base words agree
   always_comb begin
      adv_next = adv_reg;
      if (wr_adv) begin
         adv_next = {MGMT_WDATA[15], 1'b0, MGMT_WDATA[13],
                     MGMT_WDATA[12:5] & tech_mask, MGMT_WDATA[4:0]};
      end else if (BASE_DONE) begin
         adv_next[annp_pkg::PG_RFAULT] = 1'b0;
      end
      adv_next[annp_pkg::PG_MORE] = adv_next[annp_pkg::PG_MORE] && NP_ABLE;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         adv_reg <= 16'h0000;
      end else if (AN_INITIATED && restart_reg && adv_reg == 16'h0000) begin
         adv_reg <= adv_reset;
      end else begin
         adv_reg <= adv_next;
      end
   end

   // base word leaves with the advertised fault bit; no local fault sensing here
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         TX_BASE_PAGE <= 16'h0000;
      end else begin
         TX_BASE_PAGE <= {adv_reg[15], 1'b0, adv_reg[13], adv_reg[12:0]};
      end
   end

   // ==========================================
   // partner ability and expansion
   // a write to the partner register has no decode, so it has no effect
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         lp_reg         <= 16'h0000;
         lp_np_able_reg <= 1'b0;
         lp_an_able_reg <= 1'b0;
      end else begin
         lp_an_able_reg <= LP_AN_ABLE;
         if (rx_base) begin
            lp_reg         <= RX_PAGE;
            lp_np_able_reg <= RX_PAGE[annp_pkg::PG_MORE];
         end else if (rx_next) begin
            lp_reg <= RX_PAGE;
         end
      end
   end

   // latched flags: a new event in the clearing read cycle survives
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rf_status_reg <= 1'b0;
         page_rcvd_reg <= 1'b0;
         pd_fault_reg  <= 1'b0;
      end else begin
         if (rx_rfault) begin
            rf_status_reg <= 1'b1;
         end else if (rd_status) begin
            rf_status_reg <= 1'b0;
         end
         if (rx_base || rx_next) begin
            page_rcvd_reg <= 1'b1;
         end else if (rd_exp) begin
            page_rcvd_reg <= 1'b0;
         end
         if (PD_FAULT) begin
            pd_fault_reg <= 1'b1;
         end else if (rd_exp) begin
            pd_fault_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // next page transmit register and sequencer
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         np_tx_reg <= annp_pkg::NP_TX_RESET;
      end else if (wr_np) begin
         np_tx_reg <= MGMT_WDATA & annp_pkg::NP_TX_WR_MASK;
      end
   end

   annp_np_seq #(
      .CODE_MAX    (CODE_MAX)
   ) u_seq (
      .clk         (CLK),
      .rst         (RST),
      .restart     (seq_restart),
      .base_done   (BASE_DONE),
      .local_np    (adv_reg[annp_pkg::PG_MORE]),
      .lp_np       (lp_np_able_reg),
      .base_toggle (adv_reg[annp_pkg::PG_TOGGLE]),
      .np_tx_word  (np_tx_reg),
      .np_written  (wr_np),
      .tx_taken    (TX_NP_TAKEN),
      .rx_np_valid (rx_next),
      .rx_np_more  (RX_PAGE[annp_pkg::PG_MORE]),
      .tx_page     (TX_NEXT_PAGE),
      .tx_ready    (TX_NP_READY),
      .exch_active (NP_EXCHANGE),
      .exch_done   (NP_DONE)
   );

   // ==========================================
   // checks
   chk_rf_latch_set: assert property (@(posedge CLK) disable iff (RST)
      rx_rfault |=> rf_status_reg ##1 (rf_status_reg || $past(rd_status)))
      else $error("remote fault status not latched");
   chk_rf_read_clear: assert property (@(posedge CLK) disable iff (RST)
      (rd_status && !rx_rfault) |=> !rf_status_reg)
      else $error("remote fault status survived a read");
   chk_complete_gate: assert property (@(posedge CLK) disable iff (RST)
      (rd_status && !ctrl_reg[annp_pkg::CTRL_AN_EN]) |=> !MGMT_RDATA[5])
      else $error("complete bit set while negotiation disabled");
   chk_restart_pulse: assert property (@(posedge CLK) disable iff (RST)
      seq_restart |=> AN_RESTART && restart_reg ##1 !AN_RESTART || seq_restart)
      else $error("restart did not pulse once");
   chk_restart_hold: assert property (@(posedge CLK) disable iff (RST)
      (restart_reg && !AN_INITIATED) |=> restart_reg)
      else $error("restart bit dropped before initiation");
   chk_force_ignored: assert property (@(posedge CLK) disable iff (RST)
      $past(ctrl_reg[annp_pkg::CTRL_AN_EN]) |-> !FORCE_SPEED && !FORCE_DUPLEX)
      else $error("forced configuration active under negotiation");
   chk_tech_supported: assert property (@(posedge CLK) disable iff (RST)
      (adv_reg[12:5] & ~tech_mask) == 8'h00 && !adv_reg[annp_pkg::PG_ACK])
      else $error("unsupported technology advertised");
   chk_rf_follows_adv: assert property (@(posedge CLK) disable iff (RST)
      ##1 TX_BASE_PAGE[annp_pkg::PG_RFAULT] == $past(adv_reg[annp_pkg::PG_RFAULT]))
      else $error("sent remote fault differs from advertisement");
   chk_rf_base_clear: assert property (@(posedge CLK) disable iff (RST)
      (BASE_DONE && !wr_adv) |=> !adv_reg[annp_pkg::PG_RFAULT])
      else $error("remote fault kept after base negotiation");
   chk_np_stored: assert property (@(posedge CLK) disable iff (RST)
      rx_next |=> lp_reg == $past(RX_PAGE))
      else $error("received next page not stored");
   cov_remote_fault: cover property (@(posedge CLK) disable iff (RST)
      rx_rfault ##[1:20] rd_status);
   cov_np_exchange: cover property (@(posedge CLK) disable iff (RST)
      NP_EXCHANGE ##[1:200] NP_DONE);
   cov_restart: cover property (@(posedge CLK) disable iff (RST)
      seq_restart ##[1:20] AN_INITIATED);
endmodule // annp_regs

// ==== design/annp_pkg.sv ====
package annp_pkg;
   // ==========================================
   // register addresses on the management port
   localparam logic [4:0]  ADDR_CTRL      = 5'h00;
   localparam logic [4:0]  ADDR_STATUS    = 5'h01;
   localparam logic [4:0]  ADDR_ADV       = 5'h04;
   localparam logic [4:0]  ADDR_LP        = 5'h05;
   localparam logic [4:0]  ADDR_EXP       = 5'h06;
   localparam logic [4:0]  ADDR_NP_TX     = 5'h07;
   // ==========================================
   // field positions
   localparam int          CTRL_SPEED     = 13;
   localparam int          CTRL_AN_EN     = 12;
   localparam int          CTRL_RESTART   = 9;
   localparam int          CTRL_DUPLEX    = 8;
   localparam int          PG_MORE        = 15;
   localparam int          PG_ACK         = 14;
   localparam int          PG_RFAULT      = 13;
   localparam int          PG_FORMATTED   = 13;
   localparam int          PG_COMPLY      = 12;
   localparam int          PG_TOGGLE      = 11;
   localparam int          TECH_LO        = 5;
   localparam int          TECH_HI        = 12;
   // ==========================================
   // reset values, null message code and next page write mask
   localparam logic [15:0] CTRL_RESET     = 16'h1000;
   localparam logic [15:0] NP_TX_RESET    = 16'h2001;
   localparam logic [10:0] NULL_CODE      = 11'h001;
   localparam logic [15:0] NULL_PAGE      = 16'h2001;
   localparam logic [15:0] NP_TX_WR_MASK  = 16'hb7ff;

   // formatted flag selects message versus unformatted code field
   function automatic logic page_is_message(input logic [15:0] w);
      return w[PG_FORMATTED];
   endfunction

   function automatic logic [10:0] page_code(input logic [15:0] w);
      return w[10:0];
   endfunction
endpackage

// ==== design/annp_np_seq.sv ====
`timescale 1ns/1ps
module annp_np_seq #(
   parameter logic [10:0] CODE_MAX = 11'h00f
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        base_done,
   input  wire logic        local_np,
   input  wire logic        lp_np,
   input  wire logic        base_toggle,
   input  wire logic [15:0] np_tx_word,
   input  wire logic        np_written,
   input  wire logic        tx_taken,
   input  wire logic        rx_np_valid,
   input  wire logic        rx_np_more,
   output logic      [15:0] tx_page,
   output logic             tx_ready,
   output logic             exch_active,
   output logic             exch_done
);
   typedef enum logic [1:0] {IDLE, EXCH, DONE} annp_seq_type;
   annp_seq_type state_reg, state_next;
   logic        loaded_reg, last_tx_more_reg, last_rx_more_reg;
   logic        sent_reg, rcvd_reg, prev_toggle_reg;
   logic [15:0] src_word;
   logic [15:0] clean_word;
   logic        code_ok;
   logic        ready_next;
   logic        finished;
   logic        taking;
   logic        toggle_src;

   // ==========================================
   // page selection
   // reserved codes never leave the device, so they are replaced by null
   assign code_ok    = (annp_pkg::page_code(np_tx_word) != 11'h000) &&
                       (annp_pkg::page_code(np_tx_word) <= CODE_MAX);
   assign clean_word = (annp_pkg::page_is_message(np_tx_word) && !code_ok) ?
                       {np_tx_word[15:11], annp_pkg::NULL_CODE} :
                       np_tx_word;
   // nothing fresh and more promised: wait so referenced pages stay adjacent
   assign src_word   = loaded_reg ? clean_word : annp_pkg::NULL_PAGE;
   assign taking     = tx_taken && tx_ready;
   // base word or the page just taken sets the reference, so no stale toggle is shown
   assign toggle_src = base_done ? base_toggle :
                       taking ? tx_page[annp_pkg::PG_TOGGLE] : prev_toggle_reg;
   // ready rests one cycle after a take so the same page is never taken twice
   assign ready_next = (state_next == EXCH) && !taking &&
                       (loaded_reg || !last_tx_more_reg);
   assign finished   = sent_reg && rcvd_reg &&
                       !last_tx_more_reg && !last_rx_more_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         IDLE: if (base_done) begin
            state_next = (local_np && lp_np) ? EXCH : DONE;
         end
         EXCH: if (finished) begin
            state_next = DONE;
         end
         DONE: state_next = DONE;
         default: state_next = IDLE;
      endcase
      if (restart) begin
         state_next = IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg        <= IDLE;
         loaded_reg       <= 1'b1;
         last_tx_more_reg <= 1'b1;
         last_rx_more_reg <= 1'b1;
         sent_reg         <= 1'b0;
         rcvd_reg         <= 1'b0;
         prev_toggle_reg  <= 1'b0;
         tx_page          <= annp_pkg::NULL_PAGE;
         tx_ready         <= 1'b0;
         exch_active      <= 1'b0;
         exch_done        <= 1'b0;
      end else begin
         state_reg   <= state_next;
         tx_ready    <= ready_next;
         exch_active <= (state_next == EXCH);
         exch_done   <= (state_next == DONE);
         tx_page     <= {src_word[15], 1'b0, src_word[13:12], ~toggle_src,
                         src_word[10:0]};
         if (base_done) begin
            prev_toggle_reg  <= base_toggle;
            last_tx_more_reg <= 1'b1;
            last_rx_more_reg <= 1'b1;
            sent_reg         <= 1'b0;
            rcvd_reg         <= 1'b0;
         end else begin
            if (tx_taken && tx_ready) begin
               prev_toggle_reg  <= tx_page[annp_pkg::PG_TOGGLE];
               last_tx_more_reg <= tx_page[annp_pkg::PG_MORE];
               sent_reg         <= 1'b1;
            end
            if (rx_np_valid && exch_active) begin
               last_rx_more_reg <= rx_np_more;
               rcvd_reg         <= 1'b1;
            end
         end
         // a management write in the same cycle as a take still counts
         if (np_written) begin
            loaded_reg <= 1'b1;
         end else if (tx_taken && tx_ready) begin
            loaded_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // checks
   chk_exch_needs_both: assert property (@(posedge clk) disable iff (rst)
      (state_reg == IDLE && base_done && !restart && !(local_np && lp_np))
      |=> state_reg != EXCH)
      else $error("next page exchange entered without both sides able");
   chk_toggle_flips: assert property (@(posedge clk) disable iff (rst)
      (tx_taken && tx_ready && !base_done) |=> ##1
      tx_page[annp_pkg::PG_TOGGLE] != $past(tx_page[annp_pkg::PG_TOGGLE], 2))
      else $error("next page toggle did not invert");
   chk_null_when_idle: assert property (@(posedge clk) disable iff (rst)
      (tx_ready && !loaded_reg && !np_written) |-> tx_page[10:0] == annp_pkg::NULL_CODE)
      else $error("idle side sent a non-null page");
endmodule // annp_np_seq

// ==== sim/annp_partner.sv ====
`timescale 1ns/1ps
module annp_partner #(
   parameter int LAG = 1
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        send_base,
   input  wire logic [15:0] base_word,
   input  wire logic        tx_ready,
   input  wire logic        exch,
   output logic             rx_valid,
   output logic             rx_is_base,
   output logic      [15:0] rx_page,
   output logic             taken
);
   // ==========================================
   // link partner: one base page, then one null page per page taken
   logic [7:0] cnt_reg;
   logic       tog_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 8'h00;
         tog_reg <= 1'b0;
         taken <= 1'b0;
         rx_valid <= 1'b0;
         rx_is_base <= 1'b0;
         rx_page <= 16'h0000;
      end else begin
         taken <= 1'b0;
         rx_valid <= 1'b0;
         rx_is_base <= 1'b0;
         // released word keeps moving so a stale value is never mistaken for data
         rx_page <= ~rx_page;
         if (send_base) begin
            rx_valid <= 1'b1;
            rx_is_base <= 1'b1;
            rx_page <= base_word;
            tog_reg <= ~base_word[11];
         end else if (cnt_reg == 8'(LAG)) begin
            taken <= tx_ready;
            cnt_reg <= tx_ready ? cnt_reg + 8'h01 : 8'h00;
         end else if (cnt_reg == 8'(LAG + 1)) begin
            // no more to say: null message page with more_pages_flag low
            rx_valid <= 1'b1;
            rx_page <= {4'h2, tog_reg, 11'h001};
            tog_reg <= ~tog_reg;
            cnt_reg <= 8'h00;
         end else if (cnt_reg != 8'h00 || (tx_ready && exch)) begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule // annp_partner

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
   // ==========================================
   // nets
   logic        clk, rst, we, re, rx_valid, rx_base, lp_able, pd_fault, base_done;
   logic        an_init, an_cmpl, taken, an_en, an_rst, f_spd, f_dup, np_rdy, np_exch;
   logic        np_done, send_base;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, tx_base, tx_np, rx_page, seen;
   int          bad_count, check_count, cycles, n;
   annp_regs annp_regs_i (.CLK(clk), .RST(rst), .MGMT_ADDR(addr), .MGMT_WDATA(wdata),
      .MGMT_WE(we), .MGMT_RE(re), .MGMT_RDATA(rdata), .RX_PAGE_VALID(rx_valid),
      .RX_IS_BASE(rx_base), .RX_PAGE(rx_page), .LP_AN_ABLE(lp_able), .PD_FAULT(pd_fault),
      .BASE_DONE(base_done), .AN_INITIATED(an_init), .AN_COMPLETE(an_cmpl),
      .TX_NP_TAKEN(taken), .AN_ENABLE(an_en), .AN_RESTART(an_rst), .FORCE_SPEED(f_spd),
      .FORCE_DUPLEX(f_dup), .TX_BASE_PAGE(tx_base), .TX_NEXT_PAGE(tx_np),
      .TX_NP_READY(np_rdy), .NP_EXCHANGE(np_exch), .NP_DONE(np_done));
   annp_partner #(.LAG(3)) annp_partner_i (.clk(clk), .rst(rst), .send_base(send_base),
      .base_word(16'ha001), .tx_ready(np_rdy), .exch(np_exch), .rx_valid(rx_valid),
      .rx_is_base(rx_base), .rx_page(rx_page), .taken(taken));
   // ==========================================
   // shared tasks
   task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      seen = rdata;
   endtask
   task automatic test_done();
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      rd(annp_pkg::ADDR_NP_TX);
      chk("np_tx", seen, 16'h2001);
      rd(annp_pkg::ADDR_STATUS);
      chk("able", 16'(seen[3]), 16'h0001);
      chk("cmpl", 16'(seen[5]), 16'h0000);
   endtask
   task automatic t_start();
      wr(annp_pkg::ADDR_CTRL, 16'h1200);
      chk("restart", 16'(an_rst), 16'h0001);
      wr(annp_pkg::ADDR_CTRL, 16'h1000);
      chk("restart0", 16'(an_rst), 16'h0000);
      rd(annp_pkg::ADDR_CTRL);
      chk("bit9", 16'(seen[9]), 16'h0001);
      @(posedge clk);
      an_init <= 1'b1;
      @(posedge clk);
      an_init <= 1'b0;
      rd(annp_pkg::ADDR_CTRL);
      chk("bit9_init", 16'(seen[9]), 16'h0000);
      rd(annp_pkg::ADDR_ADV);
      chk("adv_default", seen, 16'h83e1);
   endtask
   task automatic t_ctrl();
      @(posedge clk);
      an_cmpl <= 1'b1;
      wr(annp_pkg::ADDR_CTRL, 16'h2100);
      @(posedge clk);
      #1;
      chk("forced", 16'({an_en, f_spd, f_dup}), 16'h0003);
      rd(annp_pkg::ADDR_STATUS);
      chk("cmpl_off", 16'(seen[5]), 16'h0000);
      wr(annp_pkg::ADDR_CTRL, 16'h3100);
      @(posedge clk);
      #1;
      chk("auto", 16'({an_en, f_spd, f_dup}), 16'h0004);
      rd(annp_pkg::ADDR_STATUS);
      chk("cmpl_on", 16'(seen[5]), 16'h0001);
   endtask
   task automatic t_link();
      wr(annp_pkg::ADDR_ADV, 16'hffff);
      rd(annp_pkg::ADDR_ADV);
      chk("adv_mask", seen, 16'ha3ff);
      chk("base_tx", tx_base, 16'ha3ff);
      wr(annp_pkg::ADDR_CTRL, 16'h1200);
      rd(annp_pkg::ADDR_CTRL);
      chk("rerun", 16'(seen[9]), 16'h0001);
      @(posedge clk);
      send_base <= 1'b1;
      @(posedge clk);
      send_base <= 1'b0;
      rd(annp_pkg::ADDR_STATUS);
      chk("rf_rx", 16'(seen[4]), 16'h0001);
      rd(annp_pkg::ADDR_STATUS);
      chk("rf_clr", 16'(seen[4]), 16'h0000);
      rd(annp_pkg::ADDR_LP);
      chk("lp_base", seen, 16'ha001);
      @(posedge clk);
      base_done <= 1'b1;
      @(posedge clk);
      base_done <= 1'b0;
      #1;
      chk("exch", 16'({np_exch, np_rdy}), 16'h0003);
      chk("np_first", tx_np, 16'h2801);
      for (n = 0; n < 100 && np_done !== 1'b1; n++)
         @(posedge clk);
      chk("done", 16'(np_done), 16'h0001);
      chk("rf_sent", 16'(tx_base[13]), 16'h0000);
      rd(annp_pkg::ADDR_LP);
      chk("lp_next", seen, 16'h2801);
      rd(annp_pkg::ADDR_EXP);
      chk("expansion", seen, 16'h000f);
   endtask
   // ==========================================
   // clock, watchdog, main sequence
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      {we, re, lp_able, pd_fault, base_done, an_init, an_cmpl, send_base} = 8'h20;
      addr = 5'h00;
      wdata = 16'h0000;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_start();
      t_ctrl();
      t_link();
      test_done();
   end
endmodule // tb
